/* design/ata_cmd_pkg.sv */
// package for the task-file command engine: offsets, opcodes, bit positions,
// reset values, state enumeration and the packed carriers of the engine.
// assumes a single 100 MHz clock domain and an 8/16-bit register port.
package ata_cmd_pkg;

    // ========================================================================
    // register offsets on the plain register port
    localparam logic [3:0] OFF_DATA   = 4'h0; // 16-bit data window (read buffer)
    localparam logic [3:0] OFF_FEAT   = 4'h1; // feature_param write / error read
    localparam logic [3:0] OFF_COUNT  = 4'h2; // transfer_count
    localparam logic [3:0] OFF_LOW    = 4'h3; // address_low_byte
    localparam logic [3:0] OFF_MID    = 4'h4; // address_mid_byte
    localparam logic [3:0] OFF_HIGH   = 4'h5; // address_high_byte
    localparam logic [3:0] OFF_DH     = 4'h6; // drive_head_select
    localparam logic [3:0] OFF_CMD    = 4'h7; // command_code write / status read
    localparam logic [3:0] OFF_ISTS   = 4'h8; // interrupt status, write one to clear
    localparam logic [3:0] OFF_IMASK  = 4'h9; // interrupt mask
    localparam logic [3:0] OFF_CFG    = 4'ha; // configuration

    // ========================================================================
    // command opcodes
    localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;
    localparam logic [7:0] OP_IDLE_IMM_B = 8'he1;
    localparam logic [7:0] OP_MEDIA_LOCK = 8'hde;
    localparam logic [7:0] OP_MEDIA_UNLK = 8'hdf;
    localparam logic [7:0] OP_NOP        = 8'h00;
    localparam logic [7:0] OP_READ_BUF   = 8'he4;
    localparam logic [7:0] OP_READ_DMA   = 8'hc8;
    localparam logic [7:0] OP_READ_DMA_X = 8'h25;

    // ========================================================================
    // field positions
    localparam int ST_BSY   = 7;  // status: busy
    localparam int ST_DRDY  = 6;  // status: ready
    localparam int ST_DRQ   = 3;  // status: data request
    localparam int ST_ERR   = 0;  // status: error
    localparam int ER_UNC   = 6;  // error: uncorrectable media error
    localparam int ER_ABRT  = 2;  // error: aborted command
    localparam int DH_LBA   = 6;  // drive/head: address mode bit
    localparam int DH_DRV   = 4;  // drive/head: drive select bit
    localparam int IS_DONE  = 0;  // interrupt event: command completed
    localparam int IS_ERR   = 1;  // interrupt event: command failed
    localparam int CFG_8BIT = 0;  // config: 8-bit transfer mode enabled

    // ========================================================================
    // reset values and sizes
    localparam logic [7:0]  RST_TF     = 8'h00;
    localparam logic [1:0]  RST_IMASK  = 2'h0;
    localparam logic [16:0] CNT28_ZERO = 17'h00100; // zero count means 256
    localparam logic [16:0] CNT48_ZERO = 17'h10000; // zero count means 65536

    // engine states
    typedef enum logic [2:0] {S_READY, S_IDLE_CMD, S_FETCH, S_XFER, S_PIO} state_t;

    // task file: current bytes, and for count and the three address bytes the byte written before them
    typedef struct packed {
        logic [7:0] feat;
        logic [7:0] cnt_p;
        logic [7:0] cnt;
        logic [7:0] lo_p;
        logic [7:0] lo;
        logic [7:0] mid_p;
        logic [7:0] mid;
        logic [7:0] hi_p;
        logic [7:0] hi;
        logic [7:0] dh;
    } tf_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage : ata_cmd_pkg

/* design/ata_cmd_engine.sv */
// task-file command engine: idle immediate, media lock/unlock, nop,
// read buffer, read dma and read dma ext, with a one-sector buffer.
// assumes all inputs synchronous to clk; the media side delivers one
// sector of 16-bit words after media_req rises, or flags an error.
//
// Functional notes
// RL1 - idle immediate: busy, idle mode, interrupt
// RL2 - media lock/unlock complete aborted
// RL3 - nop always completes aborted
// RL4 - read buffer returns buffer like sector read
// RL5 - read dma count zero means 256
// RL6 - read accepted: busy, fill buffer, then drq
// RL7 - dma request while buffered data remains
// RL8 - host acks and strobes one word per read
// RL9 - one interrupt at end or on error
// RL10 - success leaves last sector address in registers
// RL11 - error stops, failing sector address in registers
// RL12 - read dma ext count zero means 65536
// RL13 - ext leaves last or failing lba
// RL14 - ext aborted when 8-bit mode enabled
// RL15 - 48-bit registers take previous then current byte
// RL16 - 28-bit address from head, cylinder, sector bytes
// RL17 - unused fields ignored, only drive bit decoded
`timescale 1ns/1ps
`default_nettype none
module ata_cmd_engine
    import ata_cmd_pkg::*;
#(
    parameter int  SECTOR_WORDS = 256,  // 16-bit words per 512-byte sector
    parameter logic DRIVE_ID    = 1'b0  // drive select value this device answers
) (
    input  wire logic             clk,         // 100 mhz clock
    input  wire logic             rst,         // async reset, active high
    input  wire ata_cmd_pkg::reg_req_t req,    // register port request
    output logic [15:0]           rdata,       // read data, cycle after read strobe
    output logic                  irq,         // level interrupt
    output logic                  dmarq,       // dma request to host
    input  wire logic             dmack_n,     // host dma acknowledge, active low
    input  wire logic             iord_n,      // host read strobe, active low
    output logic [15:0]           dd,          // dma read word
    output logic                  media_req,   // request one sector from media
    output logic [47:0]           media_lba,   // sector address for media
    input  wire logic             media_valid, // media word valid
    input  wire logic [15:0]      media_data,  // media word
    input  wire logic             media_err,   // unrecoverable media error
    output logic                  idle_mode    // drive is in idle power mode
);

    // ========================================================================
    // state record
    typedef struct packed {
        state_t      st;       // engine state
        tf_t         tf;       // task file
        logic [7:0]  err;      // error register
        logic        bsy;      // busy
        logic        drq;      // data request
        logic        errb;     // error status bit
        logic [1:0]  ists;     // sticky interrupt events
        logic [1:0]  imask;    // interrupt mask
        logic        eight;    // 8-bit transfer mode
        logic        idle;     // idle mode
        logic        ext;      // current command uses 48-bit registers
        logic [16:0] left;     // sectors left including current
        logic [47:0] lba;      // current sector
        logic [8:0]  widx;     // word index inside the sector buffer
        logic        iord_p;   // previous read strobe level
        logic [15:0] rdata;    // read data register
        logic        irq;      // interrupt output
        logic        dmarq;    // dma request output
        logic [15:0] dd;       // dma data output
        logic        mreq;     // media request output
    } eng_t;

    eng_t        s_q;                          // registered state
    eng_t        s_d;                          // next state
    logic [15:0] buf_mem [0:SECTOR_WORDS-1];   // sector buffer
    logic [15:0] buf_rd;                       // buffer word at the index
    logic        cmd_go;                       // command accepted this cycle
    logic        drv_ok;                       // drive select matches
    logic        strobe;                       // one dma word taken
    logic        wlast;                        // index at last word
    logic [1:0]  ev;                           // interrupt events this cycle

    localparam logic [8:0] LAST_W = 9'(SECTOR_WORDS - 1);

    // ========================================================================
    // helpers
    // start address of a 28-bit command
    function automatic logic [47:0] lba28(input tf_t t);
        lba28 = {20'h00000, t.dh[3:0], t.hi, t.mid, t.lo};   // [RL16]
    endfunction : lba28

    // start address of a 48-bit command
    function automatic logic [47:0] lba48(input tf_t t);
        lba48 = {t.hi_p, t.mid_p, t.lo_p, t.hi, t.mid, t.lo}; // [RL15]
    endfunction : lba48

    // write a sector address back into the command block
    function automatic tf_t put_lba(input tf_t t, input logic [47:0] a, input logic x);
        tf_t r;
        r = t;
        r.lo  = a[7:0];
        r.mid = a[15:8];
        r.hi  = a[23:16];
        if (x) begin
            r.lo_p  = a[31:24];
            r.mid_p = a[39:32];
            r.hi_p  = a[47:40];
        end else begin
            r.dh[3:0] = a[27:24];
        end
        put_lba = r;
    endfunction : put_lba

    // ========================================================================
    // decode
    assign buf_rd = buf_mem[s_q.widx[7:0]];
    assign drv_ok = (s_q.tf.dh[DH_DRV] == DRIVE_ID);                   // [RL17]
    assign cmd_go = req.wr && (req.addr == OFF_CMD) && !s_q.bsy && !s_q.drq && drv_ok;
    assign strobe = s_q.dmarq && !dmack_n && s_q.iord_p && !iord_n;    // [RL8]
    assign wlast  = (s_q.widx == LAST_W);

    // ========================================================================
    // next-state logic
    always_comb begin
        s_d        = s_q;
        ev         = 2'b00;
        s_d.iord_p = iord_n;
        s_d.rdata  = 16'h0000;
        // task file writes; ignored while a command owns the registers
        if (req.wr && !s_q.bsy && !s_q.drq) begin
            case (req.addr)
                OFF_FEAT:  s_d.tf.feat = req.wdata;
                OFF_COUNT: begin
                    s_d.tf.cnt_p = s_q.tf.cnt;                         // [RL15]
                    s_d.tf.cnt   = req.wdata;
                end
                OFF_LOW: begin
                    s_d.tf.lo_p = s_q.tf.lo;                           // [RL15]
                    s_d.tf.lo   = req.wdata;
                end
                OFF_MID: begin
                    s_d.tf.mid_p = s_q.tf.mid;                         // [RL15]
                    s_d.tf.mid   = req.wdata;
                end
                OFF_HIGH: begin
                    s_d.tf.hi_p = s_q.tf.hi;                           // [RL15]
                    s_d.tf.hi   = req.wdata;
                end
                OFF_DH:  s_d.tf.dh = req.wdata;
                OFF_CFG: s_d.eight = req.wdata[CFG_8BIT];
                default: ;
            endcase
        end
        // interrupt mask and status registers stay writable at all times
        if (req.wr && req.addr == OFF_IMASK) begin
            s_d.imask = req.wdata[1:0];
        end
        if (req.wr && req.addr == OFF_ISTS) begin
            s_d.ists = s_q.ists & ~req.wdata[1:0];
        end
        // register reads
        if (req.rd) begin
            case (req.addr)
                OFF_DATA: s_d.rdata = (s_q.st == S_PIO) ? buf_rd : 16'h0000;
                OFF_FEAT: s_d.rdata = {8'h00, s_q.err};
                OFF_COUNT: s_d.rdata = {8'h00, s_q.tf.cnt};
                OFF_LOW:  s_d.rdata = {8'h00, s_q.tf.lo};
                OFF_MID:  s_d.rdata = {8'h00, s_q.tf.mid};
                OFF_HIGH: s_d.rdata = {8'h00, s_q.tf.hi};
                OFF_DH:   s_d.rdata = {8'h00, s_q.tf.dh};
                OFF_CMD: begin
                    s_d.rdata[ST_BSY]  = s_q.bsy;
                    s_d.rdata[ST_DRDY] = !s_q.bsy;
                    s_d.rdata[ST_DRQ]  = s_q.drq;
                    s_d.rdata[ST_ERR]  = s_q.errb;
                end
                OFF_ISTS:  s_d.rdata = {14'h0000, s_q.ists};
                OFF_IMASK: s_d.rdata = {14'h0000, s_q.imask};
                OFF_CFG:   s_d.rdata = {15'h0000, s_q.eight};
                default:   s_d.rdata = 16'h0000;
            endcase
        end
        // command dispatch and sequencing
        case (s_q.st)
            S_READY: begin
                if (cmd_go) begin
                    s_d.err  = 8'h00;
                    s_d.errb = 1'b0;
                    s_d.widx = 9'h000;
                    case (req.wdata)
                        OP_IDLE_IMM_A, OP_IDLE_IMM_B: begin
                            s_d.bsy = 1'b1;                            // [RL1]
                            s_d.st  = S_IDLE_CMD;
                        end
                        OP_READ_BUF: begin
                            s_d.drq = 1'b1;                            // [RL4]
                            s_d.st  = S_PIO;
                            ev[IS_DONE] = 1'b1;
                        end
                        OP_READ_DMA: begin
                            s_d.ext  = 1'b0;
                            s_d.lba  = lba28(s_q.tf);                  // [RL16]
                            s_d.left = (s_q.tf.cnt == 8'h00) ? CNT28_ZERO
                                       : {9'h000, s_q.tf.cnt};         // [RL5]
                            s_d.bsy  = 1'b1;                           // [RL6]
                            s_d.idle = 1'b0;
                            s_d.mreq = 1'b1;
                            s_d.st   = S_FETCH;
                        end
                        OP_READ_DMA_X: begin
                            if (s_q.eight) begin
                                s_d.err[ER_ABRT] = 1'b1;               // [RL14]
                                s_d.errb    = 1'b1;
                                ev          = 2'b11;
                            end else begin
                                s_d.ext  = 1'b1;
                                s_d.lba  = lba48(s_q.tf);
                                s_d.left = ({s_q.tf.cnt_p, s_q.tf.cnt} == 16'h0000)
                                           ? CNT48_ZERO
                                           : {1'b0, s_q.tf.cnt_p, s_q.tf.cnt}; // [RL12]
                                s_d.bsy  = 1'b1;                       // [RL6]
                                s_d.idle = 1'b0;
                                s_d.mreq = 1'b1;
                                s_d.st   = S_FETCH;
                            end
                        end
                        default: begin
                            // nop, media lock/unlock and anything unknown
                            s_d.err[ER_ABRT] = 1'b1;                   // [RL2] [RL3]
                            s_d.errb    = 1'b1;
                            ev          = 2'b11;
                        end
                    endcase
                end
            end
            S_IDLE_CMD: begin
                s_d.idle    = 1'b1;                                    // [RL1]
                s_d.bsy     = 1'b0;
                s_d.st      = S_READY;
                ev[IS_DONE] = 1'b1;
            end
            S_FETCH: begin
                // the buffer fills from media; the host sees only busy
                if (media_err) begin
                    s_d.tf      = put_lba(s_q.tf, s_q.lba, s_q.ext);  // [RL11] [RL13]
                    s_d.err[ER_UNC] = 1'b1;
                    s_d.errb    = 1'b1;
                    s_d.bsy     = 1'b0;
                    s_d.mreq    = 1'b0;
                    s_d.st      = S_READY;
                    ev          = 2'b11;                               // [RL9]
                end else if (media_valid) begin
                    s_d.widx = s_q.widx + 9'h001;
                    if (wlast) begin
                        s_d.widx  = 9'h000;
                        s_d.mreq  = 1'b0;
                        s_d.bsy   = 1'b0;                              // [RL6]
                        s_d.drq   = 1'b1;
                        s_d.dmarq = 1'b1;                              // [RL7]
                        s_d.st    = S_XFER;
                    end
                end
            end
            S_XFER: begin
                if (strobe) begin
                    s_d.dd   = buf_rd;
                    s_d.widx = s_q.widx + 9'h001;
                    if (wlast) begin
                        s_d.widx  = 9'h000;
                        s_d.dmarq = 1'b0;                              // [RL7]
                        s_d.drq   = 1'b0;
                        if (s_q.left == 17'h00001) begin
                            // lba still names the last sector read
                            s_d.tf = put_lba(s_q.tf, s_q.lba, s_q.ext); // [RL10] [RL13]
                            s_d.st = S_READY;
                            ev[IS_DONE] = 1'b1;                        // [RL9]
                        end else begin
                            // next sector; no interrupt between sectors
                            s_d.left = s_q.left - 17'h00001;           // [RL9]
                            s_d.lba  = s_q.lba + 48'h1;
                            s_d.bsy  = 1'b1;
                            s_d.mreq = 1'b1;
                            s_d.st   = S_FETCH;
                        end
                    end
                end
            end
            S_PIO: begin
                // same word order as a sector read, taken by data reads
                if (req.rd && req.addr == OFF_DATA) begin
                    s_d.widx = s_q.widx + 9'h001;                      // [RL4]
                    if (wlast) begin
                        s_d.widx = 9'h000;
                        s_d.drq  = 1'b0;
                        s_d.st   = S_READY;
                    end
                end
            end
            default: s_d.st = S_READY;
        endcase
        // events set after the clear so that a set in the same cycle wins
        s_d.ists = s_d.ists | ev;
        s_d.irq  = |(s_d.ists & s_d.imask);
    end

    // ========================================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q        <= '0;
            s_q.st     <= S_READY;
            s_q.imask  <= RST_IMASK;
            s_q.tf.dh  <= RST_TF;
            s_q.iord_p <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // sector buffer fill; no reset, contents are don't-care until written
    always_ff @(posedge clk) begin
        if (s_q.st == S_FETCH && media_valid && !media_err) begin
            buf_mem[s_q.widx[7:0]] <= media_data;
        end
    end

    // outputs straight from the state register
    assign rdata     = s_q.rdata;
    assign irq       = s_q.irq;
    assign dmarq     = s_q.dmarq;
    assign dd        = s_q.dd;
    assign media_req = s_q.mreq;
    assign media_lba = s_q.lba;
    assign idle_mode = s_q.idle;

    // ========================================================================
    // checks
    property p_idle_seq;
        @(posedge clk) disable iff (rst)
        cmd_go && (req.wdata == OP_IDLE_IMM_A || req.wdata == OP_IDLE_IMM_B) && s_q.st == S_READY
        |=> s_q.bsy ##1 (!s_q.bsy && s_q.idle && s_q.ists[IS_DONE]);
    endproperty
    a_idle_seq: assert property (p_idle_seq) else $error("idle immediate sequence wrong"); // [RL1]
    property p_abort_ops;
        @(posedge clk) disable iff (rst)
        cmd_go && s_q.st == S_READY && (req.wdata == OP_NOP || req.wdata == OP_MEDIA_LOCK
        || req.wdata == OP_MEDIA_UNLK)
        |=> s_q.errb && s_q.err[ER_ABRT] && s_q.ists[IS_ERR] && s_q.st == S_READY;
    endproperty
    a_abort_ops: assert property (p_abort_ops) else $error("nop or lock not aborted"); // [RL2]
    property p_cnt28;
        @(posedge clk) disable iff (rst)
        cmd_go && s_q.st == S_READY && req.wdata == OP_READ_DMA && s_q.tf.cnt == 8'h00
        |=> s_q.left == 17'h00100 && s_q.bsy;
    endproperty
    a_cnt28: assert property (p_cnt28) else $error("zero count not 256"); // [RL5]
    property p_cnt48;
        @(posedge clk) disable iff (rst)
        cmd_go && s_q.st == S_READY && req.wdata == OP_READ_DMA_X && !s_q.eight
        && s_q.tf.cnt == 8'h00 && s_q.tf.cnt_p == 8'h00
        |=> s_q.left == 17'h10000 && s_q.ext;
    endproperty
    a_cnt48: assert property (p_cnt48) else $error("zero ext count not 65536"); // [RL12]
    property p_eight_abort;
        @(posedge clk) disable iff (rst)
        cmd_go && s_q.st == S_READY && req.wdata == OP_READ_DMA_X && s_q.eight
        |=> s_q.err[ER_ABRT] && !s_q.bsy && !s_q.mreq;
    endproperty
    a_eight_abort: assert property (p_eight_abort) else $error("ext not aborted in 8-bit mode"); // [RL14]
    property p_dmarq_data;
        @(posedge clk) disable iff (rst)
        s_q.dmarq |-> s_q.st == S_XFER && s_q.drq && !s_q.bsy;
    endproperty
    a_dmarq_data: assert property (p_dmarq_data) else $error("dma request without data"); // [RL7]
    property p_no_sector_irq;
        @(posedge clk) disable iff (rst)
        s_q.st == S_XFER && strobe && wlast && s_q.left != 17'h00001 && !req.wr
        |=> s_q.st == S_FETCH && $stable(s_q.ists);
    endproperty
    a_no_sector_irq: assert property (p_no_sector_irq) else $error("interrupt between sectors"); // [RL9]

    property p_err_stop;
        @(posedge clk) disable iff (rst)
        s_q.st == S_FETCH && media_err
        |=> s_q.st == S_READY && s_q.errb && s_q.tf.lo == $past(s_q.lba[7:0]) && s_q.ists[IS_ERR];
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("media error not stopped"); // [RL11]

    property p_hob_shift;
        @(posedge clk) disable iff (rst)
        req.wr && req.addr == OFF_LOW && !s_q.bsy && !s_q.drq
        |=> s_q.tf.lo_p == $past(s_q.tf.lo) && s_q.tf.lo == $past(req.wdata);
    endproperty
    a_hob_shift: assert property (p_hob_shift) else $error("address byte pair wrong"); // [RL15]

endmodule : ata_cmd_engine
`default_nettype wire

/* tb/media_model.sv */
// media model: one sector of words per request, or an error pulse
// assumes the engine holds req until the sector ends
`timescale 1ns/1ps
`default_nettype none
module media_model (
    input  wire logic        clk,   // clock
    input  wire logic        req,   // sector request
    input  wire logic [47:0] lba,   // sector address
    input  wire logic [47:0] bad,   // address that fails
    output logic             valid, // word strobe
    output logic [15:0]      data,  // word
    output logic             err    // error pulse
);
    logic [8:0] idx = '0; // words sent
    initial {valid, data, err} = '0;
    // a word every other cycle; data flips when idle so no stale word shows
    always @(posedge clk) begin
        valid <= 1'b0;
        err   <= 1'b0;
        data  <= ~data;
        if (!req) idx <= '0;
        else if (!idx[8] && lba == bad) begin
            err <= 1'b1;
            idx <= 9'h100;
        end else if (!idx[8] && !valid) begin
            valid <= 1'b1;
            data  <= {lba[7:0], idx[7:0]};
            idx   <= idx + 9'h001;
        end
    end
endmodule : media_model
`default_nettype wire

/* tb/tb_top.sv */
// bench: host on the register port and dma link, media model beside
// assumes the engine answers within the bounded waits below
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ata_cmd_pkg::*;
    logic clk = 0, rst = 1, dmack_n = 1, iord_n = 1; // host lines
    reg_req_t req = '0;                               // register port
    logic [15:0] rdata, dd, mdat;                     // words
    logic irq, dmarq, mreq, mval, merr, idle;         // flags
    logic [47:0] mlba, bad = '1;                      // media address, failing one
    int errors = 0, n_tests = 0, cyc = 0;             // tallies
    // task-file writes: offset in [11:8], byte in [7:0]
    localparam logic [11:0] TF [15] = '{12'h60a, 12'h512, 12'h434, 12'h310, 12'h201, 12'h200,
        12'h202, 12'h301, 12'h320, 12'h400, 12'h400, 12'h500, 12'h500, 12'h600, 12'h377};
    localparam logic [7:0] OPS [5] = '{OP_IDLE_IMM_A, OP_IDLE_IMM_B, OP_MEDIA_LOCK, OP_MEDIA_UNLK, OP_NOP};
    always #5 clk = ~clk;
    ata_cmd_engine ata_cmd_engine_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .irq(irq),
        .dmarq(dmarq), .dmack_n(dmack_n), .iord_n(iord_n), .dd(dd), .media_req(mreq), .media_lba(mlba),
        .media_valid(mval), .media_data(mdat), .media_err(merr), .idle_mode(idle));
    media_model media_model_inst (.clk(clk), .req(mreq), .lba(mlba), .bad(bad), .valid(mval),
        .data(mdat), .err(merr));
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: %h not %h", $time, s, e);
        end
    endtask : chk
    // extra edge after the strobe so req is never assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1 chk(rdata, e);
        @(posedge clk);
    endtask : rd
    // n sectors, words {low address byte, index}; iord_n returns high between words
    task automatic sectors(input int n, input logic [7:0] b);
        dmack_n <= 1'b0;
        for (int s = 0; s < n * 256; s++) begin
            for (int i = 0; i < 3000 && !dmarq; i++) @(posedge clk);
            iord_n <= 1'b0;
            @(posedge clk);
            iord_n <= 1'b1;
            @(posedge clk);
            chk(dd, {b + 8'(s / 256), 8'(s)});
        end
        dmack_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : sectors
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // hang guard well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    // idle immediate, the aborted opcodes and the 8-bit ext refusal
    task automatic test_nondata;
        wr(OFF_IMASK, 8'h03);
        wr(OFF_DH, 8'hef);
        for (int i = 0; i < 5; i++) begin
            wr(OFF_CMD, OPS[i]);
            repeat (3) @(posedge clk);
            if (i < 2) chk({idle, irq}, 2'b11);
            else rd(OFF_FEAT, 16'h0004);
            rd(OFF_ISTS, i < 2 ? 16'h0001 : 16'h0003);
            rd(OFF_CMD, i < 2 ? 16'h0040 : 16'h0041);
            wr(OFF_ISTS, 8'h03);
        end
        wr(OFF_CFG, 8'h01);
        wr(OFF_CMD, OP_READ_DMA_X);
        repeat (2) @(posedge clk);
        rd(OFF_FEAT, 16'h0004);
        wr(OFF_CFG, 8'h00);
        wr(OFF_ISTS, 8'h03);
        $display("non-data commands done");
    endtask : test_nondata
    // 28-bit and 48-bit dma reads with the host on the link
    task automatic test_dma;
        for (int i = 0; i < 5; i++) wr(TF[i][11:8], TF[i][7:0]);
        wr(OFF_CMD, OP_READ_DMA);
        chk(mlba, 48'h00000a123410);
        chk(mreq, 1'b1);
        sectors(1, 8'h10);
        chk(dmarq, 1'b0);
        rd(OFF_LOW, 16'h0010);
        rd(OFF_ISTS, 16'h0001);
        wr(OFF_ISTS, 8'h03);
        for (int i = 5; i < 13; i++) wr(TF[i][11:8], TF[i][7:0]);
        wr(OFF_CMD, OP_READ_DMA_X);
        chk(mlba, 48'h000001000020);
        sectors(2, 8'h20);
        rd(OFF_LOW, 16'h0021);
        $display("dma reads done");
    endtask : test_dma
    // read buffer after the ext read, then media errors with zero counts
    task automatic test_buf_err;
        wr(OFF_CMD, OP_READ_BUF);
        rd(OFF_CMD, 16'h0048);
        for (int w = 0; w < 256; w++) rd(OFF_DATA, {8'h21, 8'(w)});
        wr(OFF_ISTS, 8'h03);
        bad <= 48'h000000000077;
        for (int i = 13; i < 15; i++) wr(TF[i][11:8], TF[i][7:0]);
        wr(OFF_COUNT, 8'h00); // zero count, cut short by the bad sector
        wr(OFF_CMD, OP_READ_DMA);
        repeat (30) @(posedge clk);
        rd(OFF_FEAT, 16'h0040);
        rd(OFF_LOW, 16'h0077);
        rd(OFF_ISTS, 16'h0003);
        // ext with zero count at the same bad sector; both count bytes zero
        wr(OFF_COUNT, 8'h00);
        wr(OFF_LOW, 8'h00);
        wr(OFF_LOW, 8'h77);
        wr(OFF_CMD, OP_READ_DMA_X);
        repeat (30) @(posedge clk);
        chk(mreq, 1'b0);
        rd(OFF_LOW, 16'h0077);
        $display("buffer and error done");
    endtask : test_buf_err
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_nondata();
        test_dma();
        test_buf_err();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
